// ===== verilog/bea_pkg.sv
package bea_pkg;
    // clock and timing
    localparam int unsigned BEA_CLK_HZ = 10_000_000;
    localparam int unsigned BEA_CLK_PERIOD_NS = 1_000_000_000 / BEA_CLK_HZ;
    // nominal self-timed write time, split between erase and program phases
    localparam int unsigned BEA_WRITE_TIME_US = 5000;
    localparam int unsigned BEA_WRITE_CYC_DFLT = BEA_WRITE_TIME_US * (BEA_CLK_HZ / 1_000_000);
    // longest gap allowed between two steps of the unlock sequence (rounds down)
    localparam int unsigned BEA_UNLOCK_WINDOW_NS = 2000;
    localparam int unsigned BEA_UNLOCK_WINDOW_CYC = BEA_UNLOCK_WINDOW_NS / BEA_CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [7:0] BEA_IDX_DATA = 8'h9A;
    localparam logic [7:0] BEA_IDX_ADDR = 8'h9B;
    localparam logic [7:0] BEA_IDX_CTRL = 8'h9C;
    localparam logic [7:0] BEA_IDX_KEY = 8'h9D;
    localparam logic [7:0] BEA_IDX_FLAG = 8'h9E;

    // control register fields
    localparam int unsigned BEA_CTRL_RD_BIT = 0;
    localparam int unsigned BEA_CTRL_WR_BIT = 1;
    localparam int unsigned BEA_CTRL_PERMIT_BIT = 2;
    localparam int unsigned BEA_CTRL_ABORT_BIT = 3;
    // flag register field
    localparam int unsigned BEA_FLAG_DONE_BIT = 0;

    // array geometry and reset values
    localparam int unsigned BEA_DEPTH = 128;
    localparam int unsigned BEA_LOC_W = 7;
    localparam logic [7:0] BEA_DATA_RST = 8'h00;
    localparam logic [6:0] BEA_ADDR_RST = 7'h00;
    localparam logic [7:0] BEA_ERASED_BYTE = 8'hFF;

    // unlock key values
    localparam logic [7:0] BEA_KEY_FIRST = 8'h55;
    localparam logic [7:0] BEA_KEY_SECOND = 8'hAA;

    typedef enum logic [1:0] {
        BEA_UNL_IDLE,
        BEA_UNL_GOT_FIRST,
        BEA_UNL_ARMED
    } bea_unlock_t;

    typedef enum logic [1:0] {
        BEA_PH_IDLE,
        BEA_PH_ERASE,
        BEA_PH_PROGRAM
    } bea_phase_t;

    function automatic logic [7:0] bea_reg_index(input logic [9:0] byte_addr);
        return byte_addr[9:2];
    endfunction
endpackage

// ===== verilog/bea_nvm_array.sv
`timescale 1ns/10ps
`default_nettype none
module bea_nvm_array
    import bea_pkg::*;
#(
    parameter int unsigned WRITE_CYC = BEA_WRITE_CYC_DFLT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [6:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [6:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [6:0] raddr_b,
    output logic [7:0] rdata_b,
    output logic busy,
    output logic done
);
    // WRITE_CYC must be at least 2 so both phases get a cycle
    localparam logic [31:0] ERASE_CYC = 32'(WRITE_CYC / 2);
    localparam logic [31:0] PROG_CYC = 32'(WRITE_CYC) - ERASE_CYC;

    // nonvolatile contents are never reset; they start out erased
    logic [7:0] mem [0:BEA_DEPTH-1] = '{default: BEA_ERASED_BYTE};
    bea_phase_t phase_r;
    logic [31:0] cnt_r;
    logic [6:0] wa_r;
    logic [7:0] wd_r;
    logic done_r;
    logic erase_we;
    logic prog_we;

    assign erase_we = start && (phase_r == BEA_PH_IDLE);
    assign prog_we = (phase_r == BEA_PH_PROGRAM) && (cnt_r == PROG_CYC - 32'h1) && !abort;

    // erase at start, program at the end of the timed window
    always_ff @(posedge clock) begin
        if (erase_we) begin
            mem[waddr] <= BEA_ERASED_BYTE;
        end else if (prog_we) begin
            mem[wa_r] <= wd_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wa_r <= 7'h00;
            wd_r <= 8'h00;
        end else if (erase_we) begin
            wa_r <= waddr;
            wd_r <= wdata;
        end
    end

    // an abort during programming leaves the location erased
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= BEA_PH_IDLE;
            cnt_r <= 32'h0;
        end else begin
            unique case (phase_r)
                BEA_PH_IDLE: begin
                    if (start) begin
                        phase_r <= BEA_PH_ERASE;
                        cnt_r <= 32'h0;
                    end
                end
                BEA_PH_ERASE: begin
                    if (abort) begin
                        phase_r <= BEA_PH_IDLE;
                    end else if (cnt_r == ERASE_CYC - 32'h1) begin
                        phase_r <= BEA_PH_PROGRAM;
                        cnt_r <= 32'h0;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                BEA_PH_PROGRAM: begin
                    if (abort || prog_we) begin
                        phase_r <= BEA_PH_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 32'h1;
                    end
                end
                default: phase_r <= BEA_PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= prog_we;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];
    assign busy = (phase_r != BEA_PH_IDLE);
    assign done = done_r;
endmodule
`default_nettype wire

// ===== verilog/bea_eeprom_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Holds 128 byte locations, each read and written one byte at a time.
// - Only the low seven location bits select a byte; bit 7 is ignored.
// - Eight-bit data register holds write byte and receives fetched read byte.
// - Every byte write erases the location first, then programs it.
// - An internal timer sets write duration; hardware signals completion.
// - With protection on, core still accesses array; external programmer is denied.
// - Read and write start bits are set-only; hardware clears them on completion.
// - A read completes in one cycle, then its start bit clears.
// - Array writes start only while write permit is one.
// - Write permit is zero after power-up.
// - Abort flag sets when reset cuts a write; zero after normal completion.
// - A reset that aborts a write clears data and location registers.
// - Write completion sets the done flag; only software or power-up clears it.
// - Unlock key port stores nothing and reads as zero.
// - Control register has four implemented bits; upper four read zero.
// - Control bits: abort flag 3, permit 2, write start 1, read start 0.
// - Write starts only after keys 55h then AAh, then write start bit.
// - Write start needs permit; clearing permit later leaves the write running.
// - Read data lands next cycle and stays until another read, a data register write or a warm reset.
// - Hardware never clears write permit; only software or power-up.
module bea_eeprom_ctrl
    import bea_pkg::*;
#(
    parameter int unsigned WRITE_CYC = BEA_WRITE_CYC_DFLT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_reset,
    input wire logic wdt_reset,
    input wire logic brownout,
    input wire logic code_protect,
    input wire logic prog_read,
    input wire logic [6:0] prog_addr,
    output logic [7:0] prog_rdata,
    output logic prog_denied,
    output logic write_done_flag
);
    localparam logic [7:0] UNL_WIN = 8'(BEA_UNLOCK_WINDOW_CYC);

    logic ack_r;
    logic req;
    logic acc;
    logic wr_acc;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic soft_rst;
    logic [31:0] readdata_r;
    logic [7:0] data_r;
    logic [6:0] addr_r;
    logic rd_r;
    logic wr_r;
    logic permit_r;
    logic abort_r;
    logic flag_r;
    bea_unlock_t unl_r;
    logic [7:0] gap_r;
    logic wr_set;
    logic arr_busy;
    logic arr_done;
    logic [7:0] arr_rdata_a;
    logic [7:0] arr_rdata_b;
    logic [7:0] prog_rdata_r;
    logic prog_denied_r;

    // one wait state per transfer; read data is captured at the edge that drops waitrequest
    assign req = avs_read || avs_write;
    assign acc = req && ack_r;
    assign wr_acc = avs_write && ack_r && avs_byteenable[0];
    assign idx = bea_reg_index(avs_address);
    assign wbyte = avs_writedata[7:0];
    assign soft_rst = ext_reset || wdt_reset || brownout;
    assign avs_waitrequest = req && !ack_r;
    assign avs_readdata = readdata_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    function automatic logic [7:0] read_mux(input logic [7:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            BEA_IDX_DATA: v = data_r;
            BEA_IDX_ADDR: v = {1'b0, addr_r};
            BEA_IDX_CTRL: v = {4'h0, abort_r, permit_r, wr_r, rd_r};
            BEA_IDX_KEY: v = 8'h00;
            BEA_IDX_FLAG: v = {7'h00, flag_r};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            readdata_r <= {24'h00_0000, read_mux(idx)};
        end
    end

    // unlock sequence: any other access or a too-long gap disarms it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unl_r <= BEA_UNL_IDLE;
            gap_r <= 8'h00;
        end else if (soft_rst) begin
            unl_r <= BEA_UNL_IDLE;
            gap_r <= 8'h00;
        end else if (acc) begin
            gap_r <= 8'h00;
            if (wr_acc && idx == BEA_IDX_KEY && wbyte == BEA_KEY_FIRST) begin
                unl_r <= BEA_UNL_GOT_FIRST;
            end else if (wr_acc && idx == BEA_IDX_KEY && wbyte == BEA_KEY_SECOND
                         && unl_r == BEA_UNL_GOT_FIRST) begin
                unl_r <= BEA_UNL_ARMED;
            end else begin
                unl_r <= BEA_UNL_IDLE;
            end
        end else if (unl_r != BEA_UNL_IDLE) begin
            if (gap_r >= UNL_WIN) begin
                unl_r <= BEA_UNL_IDLE;
                gap_r <= 8'h00;
            end else begin
                gap_r <= gap_r + 8'h01;
            end
        end
    end

    assign wr_set = wr_acc && idx == BEA_IDX_CTRL && wbyte[BEA_CTRL_WR_BIT] && permit_r
                    && unl_r == BEA_UNL_ARMED && !wr_r && !arr_busy && !soft_rst;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_r <= BEA_DATA_RST;
        end else if (soft_rst) begin
            data_r <= BEA_DATA_RST;
        end else if (rd_r) begin
            data_r <= arr_rdata_a;
        end else if (wr_acc && idx == BEA_IDX_DATA) begin
            data_r <= wbyte;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= BEA_ADDR_RST;
        end else if (soft_rst) begin
            addr_r <= BEA_ADDR_RST;
        end else if (wr_acc && idx == BEA_IDX_ADDR) begin
            addr_r <= wbyte[6:0];
        end
    end

    // zeros written to the start bits are ignored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= 1'b0;
        end else if (soft_rst || rd_r) begin
            rd_r <= 1'b0;
        end else if (wr_acc && idx == BEA_IDX_CTRL && wbyte[BEA_CTRL_RD_BIT]) begin
            rd_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= 1'b0;
        end else if (soft_rst || arr_done) begin
            wr_r <= 1'b0;
        end else if (wr_set) begin
            wr_r <= 1'b1;
        end
    end

    // permit survives the warm resets, which still abort a running write and clear data and location
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            permit_r <= 1'b0;
        end else if (wr_acc && idx == BEA_IDX_CTRL) begin
            permit_r <= wbyte[BEA_CTRL_PERMIT_BIT];
        end
    end

    // hardware set wins over a software write in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            abort_r <= 1'b0;
        end else if (soft_rst && wr_r) begin
            abort_r <= 1'b1;
        end else if (arr_done) begin
            abort_r <= 1'b0;
        end else if (wr_acc && idx == BEA_IDX_CTRL) begin
            abort_r <= wbyte[BEA_CTRL_ABORT_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (arr_done) begin
            flag_r <= 1'b1;
        end else if (wr_acc && idx == BEA_IDX_FLAG) begin
            flag_r <= wbyte[BEA_FLAG_DONE_BIT];
        end
    end
    assign write_done_flag = flag_r;

    // external programmer port sees zeros while protection is on
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_rdata_r <= 8'h00;
            prog_denied_r <= 1'b0;
        end else begin
            prog_denied_r <= prog_read && code_protect;
            if (prog_read) begin
                prog_rdata_r <= code_protect ? 8'h00 : arr_rdata_b;
            end
        end
    end
    assign prog_rdata = prog_rdata_r;
    assign prog_denied = prog_denied_r;

    bea_nvm_array #(
        .WRITE_CYC(WRITE_CYC)
    ) u_array (
        .clock(clock),
        .rst_n(rst_n),
        .start(wr_set),
        .abort(soft_rst && wr_r),
        .waddr(addr_r),
        .wdata(data_r),
        .raddr_a(addr_r),
        .rdata_a(arr_rdata_a),
        .raddr_b(prog_addr),
        .rdata_b(arr_rdata_b),
        .busy(arr_busy),
        .done(arr_done)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    a_read_one_cycle: assert property ($rose(rd_r) |=> !rd_r && data_r == $past(arr_rdata_a))
        else $error("read start bit or read data wrong after one cycle");
    a_read_data_held: assert property (!rd_r && !soft_rst
        && !(wr_acc && idx == BEA_IDX_DATA) |=> $stable(data_r))
        else $error("data register changed without cause");
    a_start_needs_key: assert property ($rose(wr_r)
        |-> $past(permit_r) && $past(unl_r) == BEA_UNL_ARMED)
        else $error("write started without permit and unlock");
    a_no_permit_no_write: assert property (!permit_r |=> !$rose(wr_r))
        else $error("write started while permit was clear");
    a_permit_hw_kept: assert property (!(wr_acc && idx == BEA_IDX_CTRL) |=> $stable(permit_r))
        else $error("permit changed without a software write");
    a_wr_holds: assert property (wr_r && !soft_rst && !arr_done |=> wr_r)
        else $error("write start bit dropped early");
    a_done_sets_flag: assert property (arr_done |=> flag_r && !wr_r && !abort_r)
        else $error("write completion not reported");
    a_abort_clears: assert property (soft_rst && wr_r |=> abort_r
        && data_r == BEA_DATA_RST && addr_r == BEA_ADDR_RST && !wr_r)
        else $error("aborted write not flagged or registers not cleared");
    a_abort_flag_set: assert property (soft_rst && wr_r |-> ##1 abort_r ##1 !arr_busy)
        else $error("abort flag or array stop missing");
    a_ctrl_upper_zero: assert property (
        $past(avs_read && !ack_r && idx == BEA_IDX_CTRL) |-> avs_readdata[31:4] == 28'h0)
        else $error("control upper bits not zero");
    a_key_reads_zero: assert property (
        $past(avs_read && !ack_r && idx == BEA_IDX_KEY) |-> avs_readdata == 32'h0)
        else $error("unlock key port read nonzero");
    a_loc_msb_zero: assert property (
        $past(avs_read && !ack_r && idx == BEA_IDX_ADDR) |-> avs_readdata[7] == 1'b0)
        else $error("location bit 7 read nonzero");
    a_prog_denied: assert property (prog_read && code_protect |=> prog_denied && prog_rdata == 8'h00)
        else $error("protected array visible to programmer");
    a_one_wait: assert property (req && !ack_r |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
        else $error("waitrequest held too long");

    c_read_done: cover property ($rose(rd_r) ##1 !rd_r);
    c_write_done: cover property ($rose(wr_r) ##[1:1000] arr_done);
    c_write_abort: cover property (wr_r && soft_rst);
    c_unlock_armed: cover property (unl_r == BEA_UNL_ARMED);
endmodule
`default_nettype wire

// ===== sim/bea_eeprom_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module bea_eeprom_ctrl_test;
    import bea_pkg::*;
    // short write time keeps the run small; the write waits below are derived from it
    localparam int unsigned WCYC = 40;
    localparam int unsigned CEIL = 30000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_reset = 1'b0;
    logic wdt_reset = 1'b0;
    logic brownout = 1'b0;
    logic code_protect = 1'b0;
    logic prog_read = 1'b0;
    logic [6:0] prog_addr = 7'h00;
    logic [7:0] prog_rdata;
    logic prog_denied;
    logic write_done_flag;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    logic [7:0] mem [128];
    logic [31:0] q;
    logic [6:0] a;
    logic [7:0] d;

    always #(BEA_CLK_PERIOD_NS / 2) clock = ~clock;

    bea_eeprom_ctrl #(.WRITE_CYC(WCYC)) uut (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_reset(ext_reset), .wdt_reset(wdt_reset),
        .brownout(brownout), .code_protect(code_protect), .prog_read(prog_read),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .prog_denied(prog_denied),
        .write_done_flag(write_done_flag)
    );

    function automatic logic [7:0] exp_ctrl(input int ab, input int pm, input int w,
                                            input int r);
        return {4'h0, 1'(ab), 1'(pm), 1'(w), 1'(r)};
    endfunction

    task automatic end_of_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    // the request stands until the rising edge at which waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] dt,
                       output logic [31:0] rv);
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= {24'h0, dt};
        forever begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) break;
        end
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] dt);
        logic [31:0] rv;
        bus(1'b1, idx, dt, rv);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] rv;
        bus(1'b0, idx, 8'h00, rv);
        chk_word(nm, {24'h0, e}, rv);
    endtask

    task automatic prog(input logic [6:0] pa, input logic prot, input logic [7:0] e);
        @(posedge clock);
        code_protect <= prot;
        prog_addr <= pa;
        prog_read <= 1'b1;
        @(posedge clock);
        prog_read <= 1'b0;
        @(negedge clock);
        chk_word("prog_rdata", prot ? 32'h0 : {24'h0, e}, {24'h0, prog_rdata});
        chk_bit("prog_denied", prot, prog_denied);
    endtask

    task automatic start_wr(input logic [6:0] la, input logic [7:0] dt);
        wr(BEA_IDX_DATA, dt);
        wr(BEA_IDX_ADDR, {1'b0, la});
        wr(BEA_IDX_CTRL, 8'h04);
        wr(BEA_IDX_KEY, BEA_KEY_FIRST);
        wr(BEA_IDX_KEY, BEA_KEY_SECOND);
        wr(BEA_IDX_CTRL, 8'h06);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (write_done_flag !== 1'b1 && n < WCYC + 10) begin
            @(negedge clock);
            n++;
        end
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            err_total++;
            $display("[ERR] cycle_limit expected %0d seen %0d", CEIL - 1, cyc);
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'h6AC2EA14));
        foreach (mem[i]) mem[i] = BEA_ERASED_BYTE;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rdchk("data", BEA_IDX_DATA, BEA_DATA_RST);
        rdchk("location", BEA_IDX_ADDR, 8'h00);
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 0, 0));
        rdchk("done_reg", BEA_IDX_FLAG, 8'h00);
        rdchk("unmapped", 8'h40, 8'h00);
        wr(BEA_IDX_KEY, 8'h5A);
        rdchk("key_port", BEA_IDX_KEY, 8'h00);
        wr(BEA_IDX_ADDR, 8'h85);
        rdchk("location", BEA_IDX_ADDR, 8'h05);
        wr(BEA_IDX_CTRL, 8'hF4);
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 1, 0, 0));
        // full key sequence but permit off: nothing may be written
        wr(BEA_IDX_CTRL, 8'h00);
        wr(BEA_IDX_KEY, BEA_KEY_FIRST);
        wr(BEA_IDX_KEY, BEA_KEY_SECOND);
        wr(BEA_IDX_CTRL, 8'h02);
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 0, 0));
        repeat (WCYC + 5) @(posedge clock);
        chk_bit("write_done_flag", 1'b0, write_done_flag);
        // broken unlock: keys reversed, a read in between, an over-long gap
        for (int v = 0; v < 3; v++) begin
            wr(BEA_IDX_CTRL, 8'h04);
            if (v == 0) begin
                wr(BEA_IDX_KEY, BEA_KEY_SECOND);
                wr(BEA_IDX_KEY, BEA_KEY_FIRST);
            end else begin
                wr(BEA_IDX_KEY, BEA_KEY_FIRST);
                if (v == 1) bus(1'b0, BEA_IDX_DATA, 8'h00, q);
                else repeat (25) @(posedge clock);
                wr(BEA_IDX_KEY, BEA_KEY_SECOND);
            end
            wr(BEA_IDX_CTRL, 8'h06);
            repeat (WCYC + 5) @(posedge clock);
            chk_bit("write_done_flag", 1'b0, write_done_flag);
        end
        prog(7'h05, 1'b0, mem[5]);
        // proper write, poked while it runs
        start_wr(7'h05, 8'h3C);
        prog(7'h05, 1'b0, BEA_ERASED_BYTE);
        // a fully armed second start must not touch the running write
        wr(BEA_IDX_KEY, BEA_KEY_FIRST);
        wr(BEA_IDX_KEY, BEA_KEY_SECOND);
        wr(BEA_IDX_CTRL, 8'h06);
        wr(BEA_IDX_CTRL, 8'h00);
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 1, 0));
        wait_done();
        chk_bit("write_done_flag", 1'b1, write_done_flag);
        mem[5] = 8'h3C;
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 0, 0));
        prog(7'h05, 1'b0, mem[5]);
        rdchk("done_reg", BEA_IDX_FLAG, 8'h01);
        wr(BEA_IDX_FLAG, 8'h00);
        @(negedge clock);
        chk_bit("write_done_flag", 1'b0, write_done_flag);
        // read op with bit 7 of the location set
        wr(BEA_IDX_DATA, 8'h00);
        wr(BEA_IDX_ADDR, 8'h85);
        wr(BEA_IDX_CTRL, 8'h01);
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 0, 0));
        rdchk("data", BEA_IDX_DATA, mem[5]);
        rdchk("data", BEA_IDX_DATA, mem[5]);
        // random bytes, both ends of the array first
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : 7'($urandom);
            d = 8'($urandom);
            start_wr(a, d);
            wait_done();
            mem[a] = d;
            chk_bit("write_done_flag", 1'b1, write_done_flag);
            wr(BEA_IDX_FLAG, 8'h00);
            wr(BEA_IDX_DATA, ~d);
            wr(BEA_IDX_ADDR, {1'b0, a});
            wr(BEA_IDX_CTRL, 8'h01);
            rdchk("data", BEA_IDX_DATA, mem[a]);
            prog(a, 1'b0, mem[a]);
        end
        // protection hides the array from the programmer only
        prog(a, 1'b1, 8'h00);
        wr(BEA_IDX_DATA, 8'h00);
        wr(BEA_IDX_CTRL, 8'h01);
        rdchk("data", BEA_IDX_DATA, mem[a]);
        // each warm reset source cuts a running write
        for (int s = 0; s < 3; s++) begin
            a = 7'h20 + 7'(s);
            start_wr(a, 8'h5A);
            @(posedge clock);
            ext_reset <= (s == 0);
            wdt_reset <= (s == 1);
            brownout <= (s == 2);
            @(posedge clock);
            ext_reset <= 1'b0;
            wdt_reset <= 1'b0;
            brownout <= 1'b0;
            repeat (2) @(posedge clock);
            rdchk("control", BEA_IDX_CTRL, exp_ctrl(1, 1, 0, 0));
            rdchk("data", BEA_IDX_DATA, 8'h00);
            rdchk("location", BEA_IDX_ADDR, 8'h00);
            chk_bit("write_done_flag", 1'b0, write_done_flag);
            mem[a] = BEA_ERASED_BYTE;
            prog(a, 1'b0, mem[a]);
        end
        // abort flag written as one stays set into a clean write; its completion clears it
        wr(BEA_IDX_DATA, 8'hA5);
        wr(BEA_IDX_ADDR, 8'h30);
        wr(BEA_IDX_KEY, BEA_KEY_FIRST);
        wr(BEA_IDX_KEY, BEA_KEY_SECOND);
        wr(BEA_IDX_CTRL, 8'h0E);
        wait_done();
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 1, 0, 0));
        prog(7'h30, 1'b0, 8'hA5);
        // power-up reset with permit set must clear it but keep the array
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        rdchk("control", BEA_IDX_CTRL, exp_ctrl(0, 0, 0, 0));
        prog(7'h30, 1'b0, 8'hA5);
        end_of_test();
    end
endmodule
`default_nettype wire
